// File: srtp_consts.svh
// Constants for the supervisor, reset hold and trip programming block.
// Assumes sys_clk at the rate below; included by bare name.
`ifndef SRTP_CONSTS_SVH
`define SRTP_CONSTS_SVH

`define SRTP_CLK_MHZ        200
`define SRTP_HOLD_SEL0_MS   50
`define SRTP_HOLD_SEL1_MS   100
`define SRTP_HOLD_SEL2_MS   200
`define SRTP_HOLD_SEL3_MS   300
`define SRTP_DEBOUNCE_US    20
`define SRTP_DEBOUNCE_CYC   (`SRTP_DEBOUNCE_US * `SRTP_CLK_MHZ)
`define SRTP_HOLD_W         27
`define SRTP_DBNC_W         13
`define SRTP_SLAVE_WR       8'ha0
`define SRTP_DATA_ZERO      8'h00
`define SRTP_RAISE_T1       8'h01
`define SRTP_RAISE_T2       8'h09
`define SRTP_RAISE_T3       8'h0d
`define SRTP_CLEAR_T1       8'h03
`define SRTP_CLEAR_T2       8'h0b
`define SRTP_CLEAR_T3       8'h0f
`define SRTP_NOMINAL_MV     1700
`define SRTP_MV_PER_LSB     25
`define SRTP_NOMINAL_CODE   8'(`SRTP_NOMINAL_MV / `SRTP_MV_PER_LSB)
`define SRTP_LOCK_Q4_BASE   8'hc0
`define SRTP_LOCK_HALF_BASE 8'h80
`define SRTP_BIT_ACK        4'h8
`define SRTP_PIN_SCL        0
`define SRTP_PIN_SDA        1
`define SRTP_PIN_MR         2
`define SRTP_PIN_WP         3
`define SRTP_PIN_PROG       4
`define SRTP_PIN_N          5

`endif

// File: srtp_pkg.sv
// Types shared by the supervisor block and its link receiver.
// Assumes srtp_consts.svh is on the include path.
package srtp_pkg;
    typedef struct packed {
        logic [1:0] idx;
        logic [7:0] data;
    } srtp_byte_t;

    typedef enum logic [1:0] {OP_NONE, OP_RAISE, OP_CLEAR} srtp_op_t;
    typedef enum logic [1:0] {RS_FORCED, RS_HOLD, RS_RELEASED} srtp_rst_t;
endpackage

// File: srtp_debounce.sv
// Debouncer for an already synchronised level.
// Assumes the input has passed two flip-flops on clk.
`include "srtp_consts.svh"
module srtp_debounce (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic rawIn,
    output logic      stable_q
);
    logic [`SRTP_DBNC_W-1:0] cnt_q;
    wire                     differs = rawIn != stable_q;
    wire                     settled = cnt_q == `SRTP_DBNC_W'(`SRTP_DEBOUNCE_CYC - 1);

    // A bounce restarts the count, so only a level held for the full time passes.
    always_ff @(posedge clk) begin
        if (rst || !differs) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= settled ? '0 : cnt_q + `SRTP_DBNC_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stable_q <= 1'b0;
        end else if (differs && settled) begin
            stable_q <= rawIn;
        end
    end

    debounce_time_a: assert property (@(posedge clk) disable iff (rst)
        $changed(stable_q) |-> $past(cnt_q) == `SRTP_DBNC_W'(`SRTP_DEBOUNCE_CYC - 1))
        else $error("debounced level changed before the settle time");
endmodule

// File: srtp_link_rx.sv
// Serial byte receiver clocked by the bus clock itself.
// Assumes the bus clock stops between frames; STOP is seen by the system side.
`include "srtp_consts.svh"
module srtp_link_rx
    import srtp_pkg::*;
(
    input  wire logic sclClk,
    input  wire logic rst,
    input  wire logic sdaIn,
    output logic      sdaOe,
    output srtp_byte_t rxByte,
    output logic      rxTog
);
    logic       sdaHigh_q;
    logic       startTog_q;
    logic       startAck_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [1:0] idx_q;
    logic       addrOk_q;
    wire        startPend = startTog_q != startAck_q;
    wire        ackable = (idx_q == 2'd0) ? (shift_q == `SRTP_SLAVE_WR) : (addrOk_q && idx_q != 2'd3);

    // A fall of SDA between the rising and falling clock edges is a START.
    // The reset is asynchronous because this clock may be stopped.
    always_ff @(negedge sclClk or posedge rst) begin
        if (rst) begin
            startTog_q <= 1'b0;
            sdaOe      <= 1'b0;
        end else begin
            if (sdaHigh_q && !sdaIn) begin
                startTog_q <= ~startTog_q;
            end
            sdaOe <= (bitCnt_q == `SRTP_BIT_ACK) && ackable && !(sdaHigh_q && !sdaIn);
        end
    end

    always_ff @(posedge sclClk or posedge rst) begin
        if (rst) begin
            sdaHigh_q  <= 1'b0;
            startAck_q <= 1'b0;
            bitCnt_q   <= 4'h0;
            shift_q    <= 8'h00;
            idx_q      <= 2'd0;
            addrOk_q   <= 1'b0;
            rxByte     <= '0;
            rxTog      <= 1'b0;
        end else begin
            sdaHigh_q <= sdaIn;
            if (startPend) begin
                startAck_q <= startTog_q;
                bitCnt_q   <= 4'h1;
                shift_q    <= {7'h00, sdaIn};
                idx_q      <= 2'd0;
                addrOk_q   <= 1'b0;
            end else if (bitCnt_q == `SRTP_BIT_ACK) begin
                bitCnt_q <= 4'h0;
                rxByte   <= '{idx: idx_q, data: shift_q};
                rxTog    <= ~rxTog;
                if (idx_q == 2'd0) begin
                    addrOk_q <= shift_q == `SRTP_SLAVE_WR;
                end
                if (idx_q != 2'd3) begin
                    idx_q <= idx_q + 2'd1;
                end
            end else begin
                bitCnt_q <= bitCnt_q + 4'h1;
                shift_q  <= {shift_q[6:0], sdaIn};
            end
        end
    end
endmodule

// File: srtp_supervisor.sv
// Supply supervisor: reset hold, manual reset, two fail monitors, write gating
// and trip threshold programming over the two-wire bus.
// Assumes level codes arrive on sys_clk from a converter; pins are asynchronous.
`include "srtp_consts.svh"

// What this block does
// - Reset asserted while supply under trip level.
// - Reset held for hold time after recovery.
// - Hold time chosen by selector inputs.
// - Selector codes: 50, 100, 200, 300 ms.
// - Manual reset input forces reset.
// - Manual reset input is debounced.
// - Manual reset release adds one hold time.
// - Lock bits and write-protect gate writes.
// - Monitor two trip raises fail, clears flag.
// - Monitor three trip raises fail, clears flag.
// - Flags set only while fail high.
// - Raise addresses 01h, 09h, 0Dh.
// - Raise frame with program pin high.
// - Threshold reset addresses 03h, 0Bh, 0Fh.
// - Threshold reset frame with write-protect high.
// - Threshold reset needs no write latch.
// - Threshold reset gives nominal 1.7 V.
module srtp_supervisor
    import srtp_pkg::*;
#(
    parameter int unsigned HOLD_CYC_0 = `SRTP_HOLD_SEL0_MS * `SRTP_CLK_MHZ * 1000,
    parameter int unsigned HOLD_CYC_1 = `SRTP_HOLD_SEL1_MS * `SRTP_CLK_MHZ * 1000,
    parameter int unsigned HOLD_CYC_2 = `SRTP_HOLD_SEL2_MS * `SRTP_CLK_MHZ * 1000,
    parameter int unsigned HOLD_CYC_3 = `SRTP_HOLD_SEL3_MS * `SRTP_CLK_MHZ * 1000,
    parameter logic [7:0]  TRIP1_INIT = 8'h70,
    parameter logic [7:0]  TRIP2_INIT = 8'h70,
    parameter logic [7:0]  TRIP3_INIT = 8'h70
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       sclClk,
    input  wire logic       sclPin,
    input  wire logic       sdaPin,
    output logic            sdaO,
    output logic            sdaOe,
    input  wire logic       manualResetInput,
    input  wire logic       writeProtectPin,
    input  wire logic       programVoltagePin,
    input  wire logic       resetDelaySelHi,
    input  wire logic       resetDelaySelLo,
    input  wire logic       lockRegionHi,
    input  wire logic       lockRegionLo,
    input  wire logic [7:0] supplyLevel,
    input  wire logic [7:0] mon2Input,
    input  wire logic [7:0] mon3Input,
    input  wire logic [7:0] memWriteAddr,
    input  wire logic       mon2FlagSetReq,
    input  wire logic       mon3FlagSetReq,
    output logic            resetPinO,
    output logic            resetPinOe,
    output logic            mon2FailOut,
    output logic            mon3FailOut,
    output logic            mon2FailFlag,
    output logic            mon3FailFlag,
    output logic [7:0]      supplyTripLevel,
    output logic [7:0]      mon2TripLevel,
    output logic [7:0]      mon3TripLevel,
    output logic            wiperVolWriteOk,
    output logic            wiperNvWriteOk,
    output logic            memWriteOk,
    output logic            nvWriteOk,
    output logic            volCtrlWriteOk,
    output logic            progBusy
);
    // Selector to hold length; the selector inputs are read live.
    function automatic logic [`SRTP_HOLD_W-1:0] holdLimit(input logic [1:0] sel);
        case (sel)
            2'b00:   holdLimit = `SRTP_HOLD_W'(HOLD_CYC_0);
            2'b01:   holdLimit = `SRTP_HOLD_W'(HOLD_CYC_1);
            2'b10:   holdLimit = `SRTP_HOLD_W'(HOLD_CYC_2);
            default: holdLimit = `SRTP_HOLD_W'(HOLD_CYC_3);
        endcase
    endfunction

    // Byte address to {valid, clear, target index}.
    function automatic logic [3:0] decodeTarget(input logic [7:0] addr);
        case (addr)
            `SRTP_RAISE_T1: decodeTarget = 4'b1000;
            `SRTP_RAISE_T2: decodeTarget = 4'b1001;
            `SRTP_RAISE_T3: decodeTarget = 4'b1010;
            `SRTP_CLEAR_T1: decodeTarget = 4'b1100;
            `SRTP_CLEAR_T2: decodeTarget = 4'b1101;
            `SRTP_CLEAR_T3: decodeTarget = 4'b1110;
            default:        decodeTarget = 4'b0000;
        endcase
    endfunction

    function automatic logic inLockedRegion(input logic [1:0] lock, input logic [7:0] addr);
        case (lock)
            2'b00:   inLockedRegion = 1'b0;
            2'b01:   inLockedRegion = addr >= `SRTP_LOCK_Q4_BASE;
            2'b10:   inLockedRegion = addr >= `SRTP_LOCK_HALF_BASE;
            default: inLockedRegion = 1'b1;
        endcase
    endfunction

    // Pin synchronisers: the first stage feeds only the second.
    logic [`SRTP_PIN_N-1:0] pinMeta_q;
    logic [`SRTP_PIN_N-1:0] pinSync_q;
    logic [`SRTP_PIN_N-1:0] pinPrev_q;
    wire  [`SRTP_PIN_N-1:0] pinRaw = {programVoltagePin, writeProtectPin, manualResetInput, sdaPin, sclPin};

    genvar gp;
    generate
        for (gp = 0; gp < `SRTP_PIN_N; gp++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pinMeta_q[gp] <= 1'b0;
                    pinSync_q[gp] <= 1'b0;
                    pinPrev_q[gp] <= 1'b0;
                end else begin
                    pinMeta_q[gp] <= pinRaw[gp];
                    pinSync_q[gp] <= pinMeta_q[gp];
                    pinPrev_q[gp] <= pinSync_q[gp];
                end
            end
        end
    endgenerate

    wire sclS  = pinSync_q[`SRTP_PIN_SCL];
    wire sclP  = pinPrev_q[`SRTP_PIN_SCL];
    wire sdaS  = pinSync_q[`SRTP_PIN_SDA];
    wire sdaP  = pinPrev_q[`SRTP_PIN_SDA];
    wire wpS   = pinSync_q[`SRTP_PIN_WP];
    wire progS = pinSync_q[`SRTP_PIN_PROG];
    wire busStart = sclS && sclP && sdaP && !sdaS;
    wire busStop  = sclS && sclP && !sdaP && sdaS;

    logic mrDeb;
    srtp_debounce u_mrDebounce (
        .clk      (sys_clk),
        .rst      (rst),
        .rawIn    (pinSync_q[`SRTP_PIN_MR]),
        .stable_q (mrDeb)
    );

    // Link side; only the held byte and a toggle cross back.
    srtp_byte_t rxByte;
    logic       rxTog;
    logic       linkHold_q;
    srtp_link_rx u_linkRx (
        .sclClk (sclClk),
        .rst    (linkHold_q),
        .sdaIn  (sdaPin),
        .sdaOe  (sdaOe),
        .rxByte (rxByte),
        .rxTog  (rxTog)
    );
    assign sdaO = 1'b0;

    logic rxTogMeta_q;
    logic rxTogSync_q;
    logic rxTogPrev_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rxTogMeta_q <= 1'b0;
            rxTogSync_q <= 1'b0;
            rxTogPrev_q <= 1'b0;
        end else begin
            rxTogMeta_q <= rxTog;
            rxTogSync_q <= rxTogMeta_q;
            rxTogPrev_q <= rxTogSync_q;
        end
    end
    wire byteEvt = rxTogSync_q != rxTogPrev_q;

    // Threshold levels: index 0 supply, 1 and 2 the two monitors.
    logic [7:0] trip_q [3];
    wire  [7:0] level  [3];
    assign level[0] = supplyLevel;
    assign level[1] = mon2Input;
    assign level[2] = mon3Input;
    assign supplyTripLevel = trip_q[0];
    assign mon2TripLevel   = trip_q[1];
    assign mon3TripLevel   = trip_q[2];

    // Reset sequencer.
    srtp_rst_t              rstSt_q;
    logic [`SRTP_HOLD_W-1:0] holdCnt_q;
    wire  [`SRTP_HOLD_W-1:0] holdLim = holdLimit({resetDelaySelHi, resetDelaySelLo});
    wire                     supplyLow = supplyLevel < trip_q[0];
    wire                     forceRst = supplyLow || mrDeb;
    wire                     holdDone = holdCnt_q == holdLim - `SRTP_HOLD_W'(1);

    // The hold count restarts whenever either cause returns, so a brief dip
    // always yields a full hold time.
    always_ff @(posedge sys_clk) begin
        if (rst || forceRst) begin
            rstSt_q   <= RS_FORCED;
            holdCnt_q <= '0;
        end else begin
            case (rstSt_q)
                RS_FORCED: begin
                    rstSt_q   <= RS_HOLD;
                    holdCnt_q <= '0;
                end
                RS_HOLD: begin
                    if (holdDone) begin
                        rstSt_q <= RS_RELEASED;
                    end else begin
                        holdCnt_q <= holdCnt_q + `SRTP_HOLD_W'(1);
                    end
                end
                RS_RELEASED: rstSt_q <= RS_RELEASED;
                default:     rstSt_q <= RS_FORCED;
            endcase
        end
    end
    wire resetActive = rstSt_q != RS_RELEASED;
    // Open drain: high comes from the external pull-up.
    assign resetPinO  = 1'b0;
    assign resetPinOe = !resetActive;

    // Fail monitors and their flags.
    logic [1:0] failOut_q;
    logic [1:0] flag_q;
    wire  [1:0] setReq = {mon3FlagSetReq, mon2FlagSetReq};
    genvar gm;
    generate
        for (gm = 0; gm < 2; gm++) begin : g_mon
            wire failNow = level[gm+1] > trip_q[gm+1];
            // Set wins over clear; set is only allowed while the output is high.
            wire flagD = (setReq[gm] && failOut_q[gm]) ? 1'b1 :
                         (failNow != failOut_q[gm]) ? 1'b0 : flag_q[gm];
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    failOut_q[gm] <= 1'b0;
                    flag_q[gm]    <= 1'b0;
                end else begin
                    failOut_q[gm] <= failNow;
                    flag_q[gm]    <= flagD;
                end
            end
            fail_follows_a: assert property (@(posedge sys_clk) disable iff (rst)
                level[gm+1] > trip_q[gm+1] |=> failOut_q[gm] ##0 (!$rose(failOut_q[gm]) || !flag_q[gm]))
                else $error("fail output or flag wrong after trip");
            flag_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
                $rose(flag_q[gm]) |-> $past(failOut_q[gm]) && $past(setReq[gm]))
                else $error("fail flag set while output low");
        end
    endgenerate
    assign mon2FailOut  = failOut_q[0];
    assign mon3FailOut  = failOut_q[1];
    assign mon2FailFlag = flag_q[0];
    assign mon3FailFlag = flag_q[1];

    // Write gating; volatile control bits are never blocked.
    wire [1:0] lock = {lockRegionHi, lockRegionLo};
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wiperVolWriteOk <= 1'b0;
            wiperNvWriteOk  <= 1'b0;
            memWriteOk      <= 1'b0;
            nvWriteOk       <= 1'b0;
        end else begin
            wiperVolWriteOk <= lock == 2'b00;
            wiperNvWriteOk  <= lock == 2'b00 && !wpS;
            memWriteOk      <= !wpS && !inLockedRegion(lock, memWriteAddr);
            nvWriteOk       <= !wpS;
        end
    end
    assign volCtrlWriteOk = 1'b1;

    // Frame capture on the system side. The write latch is not consulted
    // for either sequence.
    logic       frmOpen_q;
    logic [2:0] frmCnt_q;
    logic       frmSlaveOk_q;
    logic [7:0] frmAddr_q;
    logic [7:0] frmData_q;
    logic       frmWp_q;
    logic       frmProg_q;
    wire  [3:0] target = decodeTarget(frmAddr_q);
    wire        kindOk = target[2] ? frmWp_q : frmProg_q;
    wire        frameValid = frmOpen_q && frmCnt_q == 3'd3 && frmSlaveOk_q
                             && frmData_q == `SRTP_DATA_ZERO && target[3] && kindOk;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            frmOpen_q    <= 1'b0;
            frmCnt_q     <= 3'd0;
            frmSlaveOk_q <= 1'b0;
            frmAddr_q    <= 8'h00;
            frmData_q    <= 8'h00;
            frmWp_q      <= 1'b0;
            frmProg_q    <= 1'b0;
        end else if (busStart) begin
            frmOpen_q <= 1'b1;
            frmCnt_q  <= 3'd0;
            frmWp_q   <= wpS;
            frmProg_q <= progS;
        end else if (busStop) begin
            frmOpen_q <= 1'b0;
        end else if (byteEvt && frmOpen_q) begin
            if (frmCnt_q != 3'd4) begin
                frmCnt_q <= frmCnt_q + 3'd1;
            end
            case (rxByte.idx)
                2'd0:    frmSlaveOk_q <= rxByte.data == `SRTP_SLAVE_WR;
                2'd1:    frmAddr_q <= rxByte.data;
                2'd2:    frmData_q <= rxByte.data;
                default: frmSlaveOk_q <= 1'b0;
            endcase
        end
    end

    // A stopped bus clock cannot show a START or STOP to the receiver, so its
    // framing is held clear from STOP until this side has seen the next START.
    always_ff @(posedge sys_clk) begin
        linkHold_q <= rst || !(busStart || (frmOpen_q && !busStop));
    end

    // Programming starts at STOP; a raise completes when the high-voltage pin drops, a clear when write-protect drops.
    srtp_op_t   op_q;
    logic [1:0] opIdx_q;
    wire        opDone = (op_q == OP_RAISE && !progS) || (op_q == OP_CLEAR && !wpS);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            op_q    <= OP_NONE;
            opIdx_q <= 2'd0;
        end else if (op_q == OP_NONE) begin
            if (busStop && frameValid) begin
                op_q    <= target[2] ? OP_CLEAR : OP_RAISE;
                opIdx_q <= target[1:0];
            end
        end else if (opDone) begin
            op_q <= OP_NONE;
        end
    end
    assign progBusy = op_q != OP_NONE;

    logic [7:0] tripInit [3];
    assign tripInit[0] = TRIP1_INIT;
    assign tripInit[1] = TRIP2_INIT;
    assign tripInit[2] = TRIP3_INIT;
    genvar gt;
    generate
        for (gt = 0; gt < 3; gt++) begin : g_trip
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    trip_q[gt] <= tripInit[gt];
                end else if (opDone && opIdx_q == gt) begin
                    // A raise stores the level applied to the matching input.
                    trip_q[gt] <= (op_q == OP_CLEAR) ? `SRTP_NOMINAL_CODE : level[gt];
                end
            end
            clear_nominal_a: assert property (@(posedge sys_clk) disable iff (rst)
                (op_q == OP_CLEAR && opIdx_q == gt && !wpS) |=> trip_q[gt] == `SRTP_NOMINAL_CODE)
                else $error("threshold reset did not give the nominal level");
            trip_only_op_a: assert property (@(posedge sys_clk) disable iff (rst)
                $changed(trip_q[gt]) |-> $past(op_q) != OP_NONE && $past(opIdx_q) == gt)
                else $error("threshold changed without a programming operation");
        end
    endgenerate

    supply_low_a: assert property (@(posedge sys_clk) disable iff (rst)
        supplyLow |=> !resetPinOe)
        else $error("reset released while supply low");
    hold_release_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(rstSt_q == RS_RELEASED) |-> $past(rstSt_q) == RS_HOLD && $past(holdCnt_q) == $past(holdLim) - 1)
        else $error("reset released before the hold time");
    manual_force_a: assert property (@(posedge sys_clk) disable iff (rst)
        mrDeb |=> resetActive [*2])
        else $error("manual reset did not force reset");
    wp_nv_block_a: assert property (@(posedge sys_clk) disable iff (rst)
        wpS |=> !nvWriteOk && !wiperNvWriteOk && !memWriteOk)
        else $error("nonvolatile write allowed with write-protect high");
endmodule

// File: srtp_host_model.sv
// Two-wire bus master in the host's place; it writes whole three-byte frames.
// Assumes SDA is resolved outside with a pull-up and that SCL idles high between frames.
module srtp_host_model (
    output logic      scl,
    output logic      sdaLow,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    int   acks;
    logic got;
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
        acks = 0;
    end
    // One bit every 12 ns; data only moves while SCL has been low a while, so no false START or STOP.
    task automatic pulse(input logic low);
        sdaLow = low;
        #3 scl = 1'b1;
        #3 got = sda;
        #3 scl = 1'b0;
        #3;
    endtask
    task automatic frame(input logic [23:0] f);
        acks = 0;
        sdaLow = 1'b1;
        // The START is held until the device has released its receiver framing.
        #20 scl = 1'b0;
        #3;
        for (int i = 23; i >= 0; i--) begin
            pulse(~f[i]);
            if (i % 8 == 0) begin
                pulse(1'b0);
                acks += int'(got === 1'b0);
            end
        end
        sdaLow = 1'b1;
        #3 scl = 1'b1;
        #6 sdaLow = 1'b0;
        #30;
    endtask
endmodule

// File: testbench.sv
// Self-checking bench: reset hold, manual reset, fail monitors, write gating and trip programming.
// Assumes srtp_pkg and the host model are compiled first.
`include "srtp_consts.svh"
module testbench;
    import srtp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk, rst, scl, sdaLow, sdaO, sdaOe, resetPinO, resetPinOe, progBusy;
    logic       manualResetInput, writeProtectPin, programVoltagePin, resetDelaySelHi, resetDelaySelLo;
    logic       lockRegionHi, lockRegionLo, mon2FlagSetReq, mon3FlagSetReq, mon2FailOut, mon3FailOut;
    logic       mon2FailFlag, mon3FailFlag, wiperVolWriteOk, wiperNvWriteOk, memWriteOk, nvWriteOk, volCtrlWriteOk;
    logic [7:0] supplyLevel, mon2Input, mon3Input, memWriteAddr, supplyTripLevel, mon2TripLevel, mon3TripLevel;
    logic [7:0] tgt [3];
    logic [7:0] lvl;
    wire        sda = ~(sdaLow | sdaOe);
    int         errors, comparisons, n;

    srtp_supervisor #(.HOLD_CYC_0(20), .HOLD_CYC_1(40), .HOLD_CYC_2(80), .HOLD_CYC_3(120)) i_srtp_supervisor (
        .sclClk(scl),
        .sclPin(scl),
        .sdaPin(sda),
        .*
    );
    srtp_host_model i_srtp_host_model (
        .scl(scl),
        .sdaLow(sdaLow),
        .sda(sda)
    );

    function automatic int holdOf(input int s);
        return (s == 3) ? 120 : 20 << s;
    endfunction
    function automatic logic [7:0] gateOf(input logic wp, hi, lo, input logic [7:0] a);
        logic lk;
        lk = (hi & lo) | (hi & a[7]) | (lo & (a[7:6] == 2'b11));
        return {3'h0, ~(hi | lo), ~wp & ~(hi | lo), ~wp & ~lk, ~wp, 1'b1};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic results();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic waitFor(input logic busy, output int k);
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
            if (k > 9000) begin
                errors++;
                results();
            end
        end while ((busy ? progBusy : resetPinOe) !== 1'b1);
    endtask
    // Frames are only sent while reset is released, as the host should.
    task automatic prog(input logic useWp, ok, input logic [7:0] addr, data, exp, input int t);
        cyc(1);
        writeProtectPin <= useWp;
        programVoltagePin <= ~useWp;
        cyc(4);
        i_srtp_host_model.frame({`SRTP_SLAVE_WR, addr, data});
        check(8'(i_srtp_host_model.acks), 8'h03);
        if (ok) begin
            waitFor(1'b1, n);
        end else begin
            check(8'(progBusy), 8'h00);
        end
        cyc(1);
        writeProtectPin <= 1'b0;
        programVoltagePin <= 1'b0;
        cyc(6);
        check(t == 0 ? supplyTripLevel : t == 1 ? mon2TripLevel : mon3TripLevel, exp);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        rst = 1'b1;
        {manualResetInput, writeProtectPin, programVoltagePin, resetDelaySelHi, lockRegionHi, lockRegionLo} = '0;
        {mon2FlagSetReq, mon3FlagSetReq, resetDelaySelLo} = 3'h1;
        {supplyLevel, mon2Input, mon3Input, memWriteAddr} = 32'h40000000;
        tgt = '{8'h01, 8'h09, 8'h0d};
        errors = 0;
        comparisons = 0;
        void'($urandom(32'h4ed1));
        cyc(2);
        rst <= 1'b0;
        cyc(2);
        check(8'(resetPinOe), 8'h00);
        check({6'h00, resetPinO, sdaO}, 8'h00);
        for (int s = 0; s < 4; s++) begin
            {resetDelaySelHi, resetDelaySelLo} <= 2'(s);
            supplyLevel <= 8'h6f;
            cyc(3);
            check(8'(resetPinOe), 8'h00);
            supplyLevel <= 8'h70 + 8'($urandom_range(0, 15));
            waitFor(1'b0, n);
            check(8'(n >= holdOf(s) + 1 && n <= holdOf(s) + 3), 8'h01);
            cyc(1);
        end
        // A press shorter than the debounce time must not reach the reset pin.
        manualResetInput <= 1'b1;
        cyc(300);
        manualResetInput <= 1'b0;
        cyc(300);
        check(8'(resetPinOe), 8'h01);
        manualResetInput <= 1'b1;
        cyc(4100);
        check(8'(resetPinOe), 8'h00);
        manualResetInput <= 1'b0;
        waitFor(1'b0, n);
        check(8'(n >= 4001 + holdOf(3) && n <= 4010 + holdOf(3)), 8'h01);
        {mon2FlagSetReq, mon3FlagSetReq} <= 2'b11;
        {mon2Input, mon3Input} <= 16'h7070;
        cyc(3);
        check({4'h0, mon2FailOut, mon3FailOut, mon2FailFlag, mon3FailFlag}, 8'h00);
        {mon2FlagSetReq, mon3FlagSetReq} <= 2'b00;
        {mon2Input, mon3Input} <= {8'h71, 8'h71 + 8'($urandom_range(0, 100))};
        cyc(3);
        check({4'h0, mon2FailOut, mon3FailOut, mon2FailFlag, mon3FailFlag}, 8'h0c);
        {mon2FlagSetReq, mon3FlagSetReq} <= 2'b11;
        cyc(1);
        {mon2FlagSetReq, mon3FlagSetReq} <= 2'b00;
        cyc(3);
        check({4'h0, mon2FailOut, mon3FailOut, mon2FailFlag, mon3FailFlag}, 8'h0f);
        {mon2Input, mon3Input} <= 16'h7010;
        cyc(3);
        check({4'h0, mon2FailOut, mon3FailOut, mon2FailFlag, mon3FailFlag}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            {writeProtectPin, lockRegionHi, lockRegionLo} <= 3'(i);
            memWriteAddr <= 8'($urandom);
            cyc(5);
            check({3'h0, wiperVolWriteOk, wiperNvWriteOk, memWriteOk, nvWriteOk, volCtrlWriteOk},
                  gateOf(writeProtectPin, lockRegionHi, lockRegionLo, memWriteAddr));
        end
        for (int t = 0; t < 3; t++) begin
            lvl = 8'h80 + 8'($urandom_range(0, 63));
            supplyLevel <= (t == 0) ? lvl : 8'hff;
            {mon2Input, mon3Input} <= {lvl, lvl};
            prog(1'b0, 1'b1, tgt[t], 8'h00, lvl, t);
            prog(1'b0, 1'b0, tgt[t], 8'h01, lvl, t);
            prog(1'b1, 1'b0, tgt[t], 8'h00, lvl, t);
            prog(1'b1, 1'b1, tgt[t] + 8'h02, 8'h00, 8'h44, t);
            supplyLevel <= (t == 0) ? lvl - 8'h20 : 8'hff;
            {mon2Input, mon3Input} <= {lvl - 8'h20, lvl - 8'h20};
            prog(1'b0, 1'b1, tgt[t], 8'h00, lvl - 8'h20, t);
        end
        results();
    end
endmodule
